/* core/fault_status_map.vh */
// Bit positions, reset values and timing of the fault status register
`ifndef FAULT_STATUS_MAP_VH
`define FAULT_STATUS_MAP_VH
`define FAULT_STATUS_CMD 8'h12
`define FS_WIDTH 16
`define FS_TX_READY 10
`define FS_TX_ENABLED 9
`define FS_EN_PIN 8
`define FS_TWICE 7
`define FS_ONCE 6
`define FS_FAULTED 5
`define FS_UNDERVOLT 4
`define FS_LOAD_ERR 3
`define FS_OVER_PWR 2
`define FS_UNDER_PWR 1
`define FS_OVER_CUR 0
`define FS_RESERVED_ZERO 5'h00
`define FS_RSVD_HI 15
`define FS_RSVD_LO 11
`define MS_PER_S 1000
`define FS_ONCE_RST 1'b1
`define FS_FAULTED_RST 1'b1
`define FS_UNDERVOLT_RST 1'b1
`define REFAULT_WINDOW_MS 25
`define CLK_HZ 25000000
`define BIAS_WIDTH 7
`endif

/* core/laser_fault_status_register.v */
// Fault and transmitter status register with repeated-fault inhibit
// Overview of operation
// - Ready bit 10 sets when currents settle while enabled; any fault clears it.
// - Enabled bit 9 means pin and soft enable active with no fault.
// - Bit 8 follows the raw enable pin level, ignoring polarity.
// - Faulted once and twice bits only work while inhibit setting is on.
// - Faulted once bit 6 sets when transmitter is disabled after a fault.
// - Re-enabling with no fault for 25ms clears the faulted once bit.
// - Fault within 25ms of re-enable sets bit 7, locks laser off until reset or until inhibit is switched off.
// - Any fault sets faulted bit 5; it stops laser only with auto shutdown.
// - Undervoltage bit 4 always enabled, set at power-up and on event, read clears.
// - Bit 3 flags an unfinished EEPROM load; always enabled, read clears.
// - Bit 2 flags overpower in auto power control when enabled; read clears.
// - Bit 1 flags underpower in auto power control when enabled; read clears.
// - Bit 0 flags bias above bias threshold when enabled; read clears.
// - Auto shutdown on disables laser on fault; off keeps laser driven.
`timescale 1ns/100ps
`default_nettype none
`include "fault_status_map.vh"
module laser_fault_status_register #(
	parameter WINDOW_CYCLES = `REFAULT_WINDOW_MS * (`CLK_HZ / `MS_PER_S),
	parameter TW = 20
) (
	input wire clk, // 25 MHz clock
	input wire rst, // Async reset, active high
	input wire en_pin, // Raw enable pin, asynchronous
	input wire soft_en, // Software enable bit
	input wire en_polarity, // 1: pin active high
	input wire auto_shutdn_en, // Automatic shutdown enable
	input wire rep_flt_inhibit, // Repeated-fault inhibit enable
	input wire auto_power_control, // Auto power control mode
	input wire over_pwr_en, // Overpower detection enable
	input wire under_pwr_en, // Underpower detection enable
	input wire over_current_en, // Overcurrent detection enable
	input wire currents_settled, // Bias and modulation settled
	input wire undervolt_event, // Supply undervoltage seen
	input wire load_fail_event, // EEPROM load started, not finished
	input wire md_over, // Monitor current above set point
	input wire md_under, // Monitor current below set point
	input wire [`BIAS_WIDTH-1:0] bias_level, // Measured bias current
	input wire [`BIAS_WIDTH-1:0] bias_threshold, // Bias limit
	input wire rd_en, // Read strobe from serial interface
	input wire [7:0] rd_cmd, // Command code of the read
	output reg [`FS_WIDTH-1:0] rd_data, // Read data, held
	output reg rd_valid, // Read data valid pulse
	output reg laser_on // Drive the laser
);
	// Last count of the refault window, cut to the counter width on purpose
	localparam integer WIN_LAST_FULL = WINDOW_CYCLES - 1;
	localparam [TW-1:0] WIN_LAST = WIN_LAST_FULL[TW-1:0];
	reg en_meta, en_sync;
	reg en_req_d;
	reg tx_ready, faulted, once, twice;
	reg undervolt, load_err, over_pwr, under_pwr, over_cur;
	reg win_run;
	reg [TW-1:0] win_cnt;
	wire pin_active = (en_sync == en_polarity);
	wire en_req = pin_active & soft_en;
	wire set_op = over_pwr_en & auto_power_control & md_over;
	wire set_up = under_pwr_en & auto_power_control & md_under;
	wire set_oc = over_current_en & (bias_level > bias_threshold);
	wire fault_event = undervolt_event | load_fail_event | set_op | set_up | set_oc;
	wire tx_enabled = en_req & ~faulted & ~twice;
	wire rd_hit = rd_en & (rd_cmd == `FAULT_STATUS_CMD);
	wire [`FS_WIDTH-1:0] status;
	// Status word assembly
	assign status[`FS_RSVD_HI:`FS_RSVD_LO] = `FS_RESERVED_ZERO;
	assign status[`FS_TX_READY] = tx_ready;
	assign status[`FS_TX_ENABLED] = tx_enabled;
	assign status[`FS_EN_PIN] = en_sync;
	assign status[`FS_TWICE] = twice & rep_flt_inhibit;
	assign status[`FS_ONCE] = once & rep_flt_inhibit;
	assign status[`FS_FAULTED] = faulted;
	assign status[`FS_UNDERVOLT] = undervolt;
	assign status[`FS_LOAD_ERR] = load_err;
	assign status[`FS_OVER_PWR] = over_pwr;
	assign status[`FS_UNDER_PWR] = under_pwr;
	assign status[`FS_OVER_CUR] = over_cur;

	// Enable pin synchroniser
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			en_meta <= 1'b0;
			en_sync <= 1'b0;
		end else begin
			en_meta <= en_pin;
			en_sync <= en_meta;
		end
	end

	// Clear-on-read indicators, set wins over clear
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			undervolt <= `FS_UNDERVOLT_RST;
			load_err <= 1'b0;
			over_pwr <= 1'b0;
			under_pwr <= 1'b0;
			over_cur <= 1'b0;
		end else begin
			undervolt <= undervolt_event | (undervolt & ~rd_hit);
			load_err <= load_fail_event | (load_err & ~rd_hit);
			over_pwr <= set_op | (over_pwr & ~rd_hit);
			under_pwr <= set_up | (under_pwr & ~rd_hit);
			over_cur <= set_oc | (over_cur & ~rd_hit);
		end
	end

	// Faulted state and ready flag
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			faulted <= `FS_FAULTED_RST;
			tx_ready <= 1'b0;
			en_req_d <= 1'b0;
		end else begin
			en_req_d <= en_req;
			if (fault_event)
				faulted <= 1'b1;
			else if (en_req_d & ~en_req)
				faulted <= 1'b0;
			tx_ready <= tx_enabled & currents_settled & ~fault_event;
		end
	end

	// Repeated-fault inhibit sequence
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			once <= `FS_ONCE_RST;
			twice <= 1'b0;
			win_run <= 1'b0;
			win_cnt <= {TW{1'b0}};
		end else if (~rep_flt_inhibit) begin
			win_run <= 1'b0;
			win_cnt <= {TW{1'b0}};
		end else begin
			if (win_run & fault_event) begin
				twice <= 1'b1;
				win_run <= 1'b0;
			end else if (win_run & (win_cnt == WIN_LAST)) begin
				once <= 1'b0;
				win_run <= 1'b0;
			end else if (win_run) begin
				win_cnt <= win_cnt + 1'b1;
			end else if (once & ~twice & en_req & ~en_req_d) begin
				win_run <= 1'b1;
				win_cnt <= {TW{1'b0}};
			end
			// Set after the window clear so a disable in the same cycle wins
			if (faulted & en_req_d & ~en_req)
				once <= 1'b1;
		end
	end

	// Laser drive and register read port
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			laser_on <= 1'b0;
			rd_data <= {`FS_WIDTH{1'b0}};
			rd_valid <= 1'b0;
		end else begin
			laser_on <= en_req & ~(twice & rep_flt_inhibit) & ~(faulted & auto_shutdn_en);
			rd_valid <= rd_en;
			if (rd_en)
				rd_data <= rd_hit ? status : {`FS_WIDTH{1'b0}};
		end
	end
endmodule // laser_fault_status_register
`default_nettype wire

/* test/host_model.sv */
// Host side model issuing status reads
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire logic clk, // Clock
	output logic rd_en, // Read strobe
	output logic [7:0] rd_cmd // Command code
);
	initial rd_en = 1'b0;
	initial rd_cmd = 8'h00;
	// One-cycle request; the released command line shows its inverse
	task rd(input logic [7:0] c);
		@(negedge clk);
		rd_en = 1'b1;
		rd_cmd = c;
		@(negedge clk);
		rd_en = 1'b0;
		rd_cmd = ~c;
	endtask
endmodule // host_model
`default_nettype wire

/* test/laser_fault_status_register_bench.sv */
// Self-checking bench for the fault status register
`timescale 1ns/100ps
`default_nettype none
module laser_fault_status_register_bench;
	logic clk = 0, rst = 1, en_pin = 0, soft_en = 0, inh = 1, cs = 1;
	logic [4:0] ev = 0; // Undervolt, load, over, under, overcurrent
	logic [6:0] thr = 0;
	logic [31:0] s = 32'h7aa7;
	logic [31:0] q[$];
	wire rd_en, rd_valid, laser_on;
	wire [7:0] rd_cmd;
	wire [15:0] rd_data;
	int num_errors = 0, n_compared = 0;
	initial forever #20 clk = ~clk;
	host_model host (.clk(clk), .rd_en(rd_en), .rd_cmd(rd_cmd));
	laser_fault_status_register #(.WINDOW_CYCLES(50)) uut (.clk(clk), .rst(rst), .en_pin(en_pin),
		.soft_en(soft_en), .en_polarity(1'b1), .auto_shutdn_en(inh), .rep_flt_inhibit(inh),
		.auto_power_control(1'b1), .over_pwr_en(1'b1), .under_pwr_en(1'b1), .over_current_en(cs),
		.currents_settled(cs), .undervolt_event(ev[4]), .load_fail_event(ev[3]), .md_over(ev[2]),
		.md_under(ev[1]), .bias_level({7{ev[0]}}), .bias_threshold(thr), .rd_en(rd_en),
		.rd_cmd(rd_cmd), .rd_data(rd_data), .rd_valid(rd_valid), .laser_on(laser_on));
	function automatic [31:0] nx(input logic [31:0] v);
		nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Note the masked expectation, then read
	task rd(input logic [7:0] c, input logic [15:0] m, input logic [15:0] v);
		q.push_back({m, v});
		host.rd(c);
	endtask
	task cmp1(input logic v);
		n_compared++;
		if (laser_on !== v) begin
			num_errors++;
			$display("CHECK FAILED laser_on expected %b seen %b", v, laser_on);
		end
	endtask
	task cmp16(input logic [15:0] m, input logic [15:0] v);
		n_compared++;
		if ((rd_data & m) !== v) begin
			num_errors++;
			$display("CHECK FAILED rd_data expected %h seen %h", v, rd_data & m);
		end
	endtask
	// Oldest note against each answer
	always @(negedge clk) if (rd_valid === 1'b1) begin
		cmp16(q[0][31:16], q[0][15:0]);
		void'(q.pop_front());
	end
	task print_verdict;
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		print_verdict;
	end
	initial begin
		repeat (6) @(negedge clk);
		rst = 0;
		thr = s[6:0] & 7'h7e;
		s = nx(s);
		rd(8'h12, 16'hffff, 16'h0070);
		rd(8'h12, 16'hffff, 16'h0060);
		rd(s[7:0] | 8'h80, 16'hffff, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			@(negedge clk) ev = 5'h01 << i;
			@(posedge clk);
			fork
				rd(8'h12, 16'h001f, 16'h0001 << i);
				@(negedge clk) ev = 0;
			join
		end
		{en_pin, soft_en} = 2'b11;
		repeat (60) @(negedge clk);
		rd(8'h12, 16'h0140, 16'h0100);
		soft_en = 0;
		repeat (4) @(negedge clk);
		rd(8'h12, 16'h0260, 16'h0040);
		soft_en = 1;
		repeat (4) @(negedge clk);
		rd(8'h12, 16'h0620, 16'h0600);
		cmp1(1'b1);
		ev = 5'h08;
		@(negedge clk) ev = 0;
		repeat (4) @(negedge clk);
		rd(8'h12, 16'h06a0, 16'h00a0);
		cmp1(1'b0);
		inh = 0;
		repeat (4) @(negedge clk);
		rd(8'h12, 16'h00c0, 16'h0000);
		cmp1(1'b1);
		repeat (3) @(negedge clk);
		print_verdict;
	end
endmodule // laser_fault_status_register_bench
`default_nettype wire

/* test/laser_fault_status_register_sva.sv */
// Assertions on the fault status register ports
`timescale 1ns/100ps
`default_nettype none
module fault_status_sva (
	input wire clk, rst, en_pin, soft_en, rep_flt_inhibit, // Controls
	input wire undervolt_event, over_current_en, rd_en, rd_valid, laser_on, // Strobes
	input wire auto_shutdn_en, // Shutdown setting
	input wire [6:0] bias_level, bias_threshold, // Bias compare
	input wire [7:0] rd_cmd, // Command
	input wire [15:0] rd_data // Read word
);
	wire rq = rd_en && rd_cmd == 8'h12; // Status read taken
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_ANSWER: assert property (rd_en |=> rd_valid) else $error("no answer");
	AST_RSVD: assert property (rd_valid |-> rd_data[15:11] == 5'h00)
		else $error("reserved set");
	AST_REFUSE: assert property (rd_en && !rq |=> rd_data == 16'h0000)
		else $error("unmapped data");
	AST_FAULT: assert property (undervolt_event ##1 rq |=> rd_data[5] && !rd_data[10])
		else $error("fault not shown");
	AST_COR: assert property ((rq && !undervolt_event) ##1 !undervolt_event
		##1 (rq && !undervolt_event) |=> !rd_data[4]) else $error("no clear");
	AST_OC: assert property (over_current_en && bias_level > bias_threshold
		##1 rq |=> rd_data[0]) else $error("overcurrent lost");
	AST_PIN: assert property (en_pin[*4] ##0 rq |=> rd_data[8])
		else $error("pin state");
	AST_LOCK: assert property (rd_valid && rd_data[7] && rep_flt_inhibit |-> !laser_on)
		else $error("laser not locked");
	AST_INH: assert property (!rep_flt_inhibit[*3] ##0 rq |=> rd_data[7:6] == 2'b00)
		else $error("inhibit bits");
	AST_SHUT: assert property (rd_valid && rd_data[5] && $past(auto_shutdn_en) |-> !laser_on)
		else $error("laser on while faulted");
endmodule // fault_status_sva
bind laser_fault_status_register fault_status_sva chk (.*);
`default_nettype wire
